// file: src/pin_sync.sv
`timescale 1ns/100ps
// Three-stage synchroniser; output changes once stages two and three agree
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic pinIn,
  output logic pinOut
);
  logic [sar_seq_pkg::SYNC_STAGES-1:0] stage_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stage_r <= {sar_seq_pkg::SYNC_STAGES{RESET_VAL}};
    end else begin
      stage_r <= {stage_r[sar_seq_pkg::SYNC_STAGES-2:0], pinIn};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pinOut <= RESET_VAL;
    end else if (stage_r[1] == stage_r[2]) begin
      pinOut <= stage_r[2];
    end
  end
endmodule

// file: src/sar_conversion_sequencer.sv
`timescale 1ns/100ps
module sar_conversion_sequencer #(
  parameter int RESULT_BITS = sar_seq_pkg::RESULT_BITS,
  parameter int BIT_SETTLE_CYCLES = sar_seq_pkg::BIT_SETTLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic chipSelect_n,
  input wire logic convert_start_n,
  input wire logic compKeep,
  output logic busy,
  output logic compZero,
  output logic [RESULT_BITS-1:0] dacCode,
  output logic [RESULT_BITS-1:0] resultData,
  output logic acqReady
);
  localparam int BIT_IDX_W = $clog2(RESULT_BITS);
  localparam int SETTLE_W = $clog2(BIT_SETTLE_CYCLES + 1);
  localparam int ACQ_W = $clog2(sar_seq_pkg::ACQ_MIN_CYCLES + 1);
  localparam logic [BIT_IDX_W-1:0] MSB_IDX = BIT_IDX_W'(RESULT_BITS - 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(BIT_SETTLE_CYCLES - 1);
  localparam logic [ACQ_W-1:0] ACQ_LAST = ACQ_W'(sar_seq_pkg::ACQ_MIN_CYCLES);

  sar_seq_pkg::seq_state_t state_r;
  logic csSync;
  logic startSync;
  logic startSyncDly_r;
  logic startEdge;
  logic [RESULT_BITS-1:0] approximation_register_r;
  logic [BIT_IDX_W-1:0] bitIdx_r;
  logic [SETTLE_W-1:0] settle_r;
  logic [ACQ_W-1:0] acqCnt_r;
  logic bitDone;
  logic inClear;
  logic inLoad;
  logic decide;
  logic lastBit;

  // Both pins cross into sys_clk the same way, so their latencies match and
  // chip select still qualifies the start edge it was set up for
  localparam int PIN_COUNT = 2;
  localparam int PIN_CS = 0;
  localparam int PIN_START = 1;
  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] pinSynced;

  assign pinRaw[PIN_CS] = chipSelect_n;
  assign pinRaw[PIN_START] = convert_start_n;

  for (genvar p = 0; p < PIN_COUNT; p++) begin : gPin
    pin_sync #(
      .RESET_VAL(1'b1)
    ) pin_sync_i (
      .sys_clk(sys_clk),
      .srst(srst),
      .pinIn(pinRaw[p]),
      .pinOut(pinSynced[p])
    );
  end

  assign csSync = pinSynced[PIN_CS];
  assign startSync = pinSynced[PIN_START];

  // Resets to the idle pin level, so leaving reset shows no false falling edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      startSyncDly_r <= 1'b1;
    end else begin
      startSyncDly_r <= startSync;
    end
  end

  // Falling edge qualified by chip select low
  assign startEdge = startSyncDly_r && !startSync && !csSync;
  assign bitDone = (settle_r == SETTLE_LAST);
  assign inClear = (state_r == sar_seq_pkg::ST_CLEAR);
  assign inLoad = (state_r == sar_seq_pkg::ST_LOAD);
  // A bit is decided on the last cycle of its settle window
  assign decide = (state_r == sar_seq_pkg::ST_CONVERT) && bitDone;
  assign lastBit = (bitIdx_r == '0);

  // Sequencer runs only on sys_clk; no external conversion clock needed
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= sar_seq_pkg::ST_ACQUIRE;
    end else begin
      unique case (state_r)
        sar_seq_pkg::ST_ACQUIRE: begin
          if (startEdge) begin
            state_r <= sar_seq_pkg::ST_CLEAR;
          end
        end
        // Edges seen here and below are dropped, never queued
        sar_seq_pkg::ST_CLEAR: begin
          state_r <= sar_seq_pkg::ST_CONVERT;
        end
        sar_seq_pkg::ST_CONVERT: begin
          if (decide && lastBit) begin
            state_r <= sar_seq_pkg::ST_LOAD;
          end
        end
        sar_seq_pkg::ST_LOAD: begin
          state_r <= sar_seq_pkg::ST_ACQUIRE;
        end
      endcase
    end
  end

  // Cycles the current trial has had to settle on the comparator
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      settle_r <= '0;
    end else if (state_r != sar_seq_pkg::ST_CONVERT || bitDone) begin
      settle_r <= '0;
    end else begin
      settle_r <= settle_r + SETTLE_W'(1);
    end
  end

  // Walks from MSB to LSB and rests at zero through the load
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bitIdx_r <= MSB_IDX;
    end else if (state_r == sar_seq_pkg::ST_CLEAR) begin
      bitIdx_r <= MSB_IDX;
    end else if (state_r == sar_seq_pkg::ST_CONVERT && bitDone && bitIdx_r != '0) begin
      bitIdx_r <= bitIdx_r - BIT_IDX_W'(1);
    end
  end

  // One slice per bit: the trial flop is steered by the bit index, the latch by the load.
  // The comparator judges an offset-binary trial; flipping the MSB gives two's complement.
  for (genvar b = 0; b < RESULT_BITS; b++) begin : gBit
    localparam logic IS_MSB = (b == RESULT_BITS - 1);
    logic isTrial;
    logic isNext;

    assign isTrial = (bitIdx_r == BIT_IDX_W'(b));
    assign isNext = (bitIdx_r == BIT_IDX_W'(b + 1));

    // Cleared at cycle start with only the MSB raised as the first trial
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        approximation_register_r[b] <= 1'b0;
      end else if (inClear) begin
        approximation_register_r[b] <= IS_MSB;
      end else if (decide && isTrial) begin
        approximation_register_r[b] <= compKeep;
      end else if (decide && isNext) begin
        // Raising the next trial on the deciding edge saves a cycle per bit
        approximation_register_r[b] <= 1'b1;
      end
    end

    // Latched on the same edge on which busy rises
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        resultData[b] <= 1'b0;
      end else if (inLoad) begin
        resultData[b] <= approximation_register_r[b] ^ IS_MSB;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy <= 1'b1;
    end else if (state_r == sar_seq_pkg::ST_ACQUIRE && startEdge) begin
      busy <= 1'b0;
    end else if (state_r == sar_seq_pkg::ST_LOAD) begin
      // Rises with the latch load, so data is valid at the edge
      busy <= 1'b1;
    end
  end

  // Released on the edge busy falls, so comparing starts with the clear cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      compZero <= 1'b1;
    end else begin
      compZero <= (state_r == sar_seq_pkg::ST_ACQUIRE && !startEdge)
                  || state_r == sar_seq_pkg::ST_LOAD;
    end
  end

  // The DAC follows the register flops directly; a registered copy would lag the
  // trial by a cycle and a one-cycle settle would then judge the previous trial
  assign dacCode = approximation_register_r;

  // Status only: the host is trusted to wait; early requests still convert
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      acqCnt_r <= ACQ_LAST;
    end else if (state_r != sar_seq_pkg::ST_ACQUIRE) begin
      acqCnt_r <= '0;
    end else if (acqCnt_r != ACQ_LAST) begin
      acqCnt_r <= acqCnt_r + ACQ_W'(1);
    end
  end

  assign acqReady = (acqCnt_r == ACQ_LAST);
endmodule

// file: src/sar_seq_pkg.sv
package sar_seq_pkg;
  localparam int RESULT_BITS = 12;
  localparam int CLK_PERIOD_PS = 4000;
  // Acquire time the host must leave between conversions
  localparam int ACQ_MIN_PS = 50000;
  localparam int ACQ_MIN_CYCLES = (ACQ_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Settling cycles allowed per bit trial
  localparam int BIT_SETTLE_CYCLES = 4;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    ST_ACQUIRE,
    ST_CLEAR,
    ST_CONVERT,
    ST_LOAD
  } seq_state_t;
endpackage

// file: tb/comp_model.sv
`timescale 1ns/100ps
module comp_model (
  input wire logic sys_clk,
  input wire logic busy,
  input wire logic [11:0] level,
  input wire logic [11:0] dacCode,
  output logic compKeep
);
  logic [11:0] held_r;
  // Tracks the input while acquiring, frozen once a conversion runs
  always_ff @(posedge sys_clk) begin
    if (busy) held_r <= level;
  end
  assign compKeep = (dacCode <= held_r);
endmodule

// file: tb/sar_conversion_sequencer_bench.sv
`timescale 1ns/100ps
module sar_conversion_sequencer_bench;
  logic sys_clk = 0, srst = 1, chipSelect_n = 1, convert_start_n = 1, compKeep, busy;
  logic [11:0] level = 12'h000, dacCode, resultData;
  logic [11:0] corners [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
  int miscompares = 0, compares = 0, lows;
  always #2 sys_clk = ~sys_clk;
  sar_conversion_sequencer #(.BIT_SETTLE_CYCLES(1)) sar_conversion_sequencer_i (
    .sys_clk(sys_clk), .srst(srst), .chipSelect_n(chipSelect_n),
    .convert_start_n(convert_start_n), .compKeep(compKeep), .busy(busy),
    .compZero(), .dacCode(dacCode), .resultData(resultData), .acqReady());
  comp_model comp_model_i (.sys_clk(sys_clk), .busy(busy), .level(level),
    .dacCode(dacCode), .compKeep(compKeep));
  function automatic logic [11:0] expect_code(logic [11:0] v);
    return v ^ 12'h800;
  endfunction
  task summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(string n, logic [11:0] e, logic [11:0] s);
    compares++;
    if (e !== s) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task pulse;
    convert_start_n = 0;
    repeat (6) @(negedge sys_clk);
    convert_start_n = 1;
  endtask
  task conv(logic [11:0] v, bit again);
    int k;
    level = v;
    pulse();
    chk("busy low", 12'h000, {11'h000, busy});
    if (again) begin
      repeat (3) @(negedge sys_clk);
      level = ~v;
      pulse();
    end
    k = 0;
    while (busy !== 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    chk("busy rise", 12'h001, {11'h000, busy});
    chk("result", expect_code(v), resultData);
    repeat (16) @(negedge sys_clk);
    $display("test %h done", v);
  endtask
  initial begin
    #50000;
    $display("[FAIL] watchdog expected finish seen timeout");
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(54366));
    repeat (6) @(negedge sys_clk);
    srst = 0;
    repeat (4) @(negedge sys_clk);
    chipSelect_n = 0;
    repeat (8) @(negedge sys_clk);
    foreach (corners[i]) conv(corners[i], 0);
    conv(12'h5A3, 1);
    chipSelect_n = 1;
    repeat (8) @(negedge sys_clk);
    pulse();
    lows = 0;
    repeat (20) @(negedge sys_clk) lows += (busy !== 1'b1);
    chk("deselected", 12'h000, lows[11:0]);
    $display("test deselect done");
    chipSelect_n = 0;
    repeat (8) @(negedge sys_clk);
    repeat (20) conv(12'($urandom), 0);
    summarize();
  end
endmodule

// file: tb/sar_seq_checker_sva.sv
`timescale 1ns/100ps
module sar_seq_checker #(
  parameter int RESULT_BITS = 12,
  parameter int BIT_SETTLE_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic chipSelect_n,
  input wire logic convert_start_n,
  input wire logic compKeep,
  input wire logic busy,
  input wire logic compZero,
  input wire logic [RESULT_BITS-1:0] dacCode,
  input wire logic [RESULT_BITS-1:0] resultData,
  input wire logic acqReady
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_cs_gate: assert property ((busy && chipSelect_n) [*8] |=> busy)
    else $error("busy fell while deselected");
  a_start_sel: assert property ($fell(busy) |-> !$past(chipSelect_n, 4))
    else $error("start without chip select");
  a_start_edge: assert property ($fell(busy) |-> $past(convert_start_n, 6))
    else $error("start without falling edge");
  a_clear_first: assert property ($fell(busy) |-> ##[0:2] dacCode == 12'h800)
    else $error("first trial not msb alone");
  a_busy_span: assert property ($fell(busy) |-> (!busy) [*8] ##[1:300] busy)
    else $error("busy low span wrong");
  a_zero_acq: assert property (compZero == busy)
    else $error("zeroing out of phase");
  a_result_hold: assert property (!$rose(busy) |-> $stable(resultData))
    else $error("result changed without busy rise");
  a_acq_ready: assert property ($rose(busy) |=> (!acqReady) [*8] ##[1:8] acqReady)
    else $error("acquire ready timing wrong");
endmodule
bind sar_conversion_sequencer sar_seq_checker #(.RESULT_BITS(RESULT_BITS),
  .BIT_SETTLE_CYCLES(BIT_SETTLE_CYCLES)) sar_seq_checker_i (.sys_clk(sys_clk),
  .srst(srst), .chipSelect_n(chipSelect_n), .convert_start_n(convert_start_n),
  .compKeep(compKeep), .busy(busy), .compZero(compZero), .dacCode(dacCode),
  .resultData(resultData), .acqReady(acqReady));
